// [friction_torque_compensation.sv]
// Friction torque compensation and third-gain period control
//
// Contract
// - Third gain: first position/velocity gains times scale over 100; others unchanged.
// - Outside torque control, add signed offset-load setting to torque command.
// - Forward positional command adds the forward friction setting.
// - Reverse positional command adds the reverse friction setting.
// - Total compensation is offset term plus direction-selected dynamic term.
// - Direction state clears at power-up and when motor is de-energised.
// - Torque control forces both terms to zero.
// - Velocity control with servo off: offset applied, dynamic term zero.
// - Position/full-closed servo on: hold terms until first command, then load offset.
// - After a command in position/full-closed, dynamic term follows command direction.
// - Second-gain condition during third gain switches to second gain.
// - Third-gain period timed from valid-time setting in 0.1 ms, 0 to 10000.
`default_nettype none
`include "friction_torque_compensation_defines.svh"

module friction_torque_compensation #(
    parameter int CMD_W       = 32,
    parameter int TQ_W        = 16,
    parameter int SET_W       = 8,
    parameter int GAIN_W      = 16,
    parameter int SCALE_W     = 11,
    parameter int VT_W        = 14,
    parameter int TICK_CYCLES = `FTC_TICK_CYCLES
) (
    input  wire logic                                        i_clk_sys,
    input  wire logic                                        i_rst_n,
    input  wire friction_torque_compensation_pkg::ctrl_mode_e i_control_mode,
    input  wire logic                                        i_servo_on,
    input  wire logic                                        i_motor_energized,
    input  wire logic                                        i_cmd_valid,
    input  wire logic signed [CMD_W-1:0]                     i_cmd_delta,
    input  wire logic signed [TQ_W-1:0]                      i_torque_cmd,
    input  wire logic signed [SET_W-1:0]                     i_torque_offset_setting,
    input  wire logic signed [SET_W-1:0]                     i_forward_friction_setting,
    input  wire logic signed [SET_W-1:0]                     i_reverse_friction_setting,
    input  wire logic [GAIN_W-1:0]                           i_first_position_gain,
    input  wire logic [GAIN_W-1:0]                           i_first_velocity_gain,
    input  wire logic [GAIN_W-1:0]                           i_second_position_gain,
    input  wire logic [GAIN_W-1:0]                           i_second_velocity_gain,
    input  wire logic [SCALE_W-1:0]                          i_third_gain_scale,
    input  wire logic [VT_W-1:0]                             i_third_gain_valid_time,
    input  wire logic                                        i_second_gain_cond,
    output logic signed [TQ_W-1:0]                           o_torque_cmd,
    output logic signed [SET_W-1:0]                          o_offset_term,
    output logic signed [SET_W-1:0]                          o_dynamic_term,
    output friction_torque_compensation_pkg::cmd_dir_e       o_cmd_dir,
    output friction_torque_compensation_pkg::gain_set_e      o_gain_set,
    output logic [GAIN_W+3:0]                                o_position_gain,
    output logic [GAIN_W+3:0]                                o_velocity_gain
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        friction_torque_compensation_pkg::gain_set_e gain;
        logic [VT_W-1:0]                             period;
        logic [TICK_W-1:0]                           tick;
        friction_torque_compensation_pkg::cmd_dir_e  dir;
        logic                                        cmd_seen;
        logic signed [SET_W-1:0]                     offset;
        logic signed [SET_W-1:0]                     dyn;
        logic [GAIN_W+3:0]                           pos_gain;
        logic [GAIN_W+3:0]                           vel_gain;
        logic signed [TQ_W-1:0]                      torque;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    logic [GAIN_W+3:0]  third_pos_gain;
    logic [GAIN_W+3:0]  third_vel_gain;
    logic               pos_like;
    logic [VT_W-1:0]    valid_time;

    loop_gain_scaler #(.GAIN_W(GAIN_W), .SCALE_W(SCALE_W)) u_pos_scaler (
        .i_gain  (i_first_position_gain),
        .i_scale (i_third_gain_scale),
        .o_gain  (third_pos_gain)
    );

    loop_gain_scaler #(.GAIN_W(GAIN_W), .SCALE_W(SCALE_W)) u_vel_scaler (
        .i_gain  (i_first_velocity_gain),
        .i_scale (i_third_gain_scale),
        .o_gain  (third_vel_gain)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        friction_torque_compensation_pkg::cmd_dir_e new_dir;
        logic signed [SET_W-1:0] dir_term;
        new_dir  = st_ff.dir;
        dir_term = '0;
        nxt_st   = st_ff;

        pos_like = (i_control_mode == friction_torque_compensation_pkg::MODE_POSITION)
                || (i_control_mode == friction_torque_compensation_pkg::MODE_FULL_CLOSED);
        valid_time = (i_third_gain_valid_time > `FTC_VALID_TIME_MAX) ? `FTC_VALID_TIME_MAX
                                                                     : i_third_gain_valid_time;

        // Gain set selection
        case (st_ff.gain)
            friction_torque_compensation_pkg::GAIN_FIRST: begin
                if (i_second_gain_cond) begin
                    nxt_st.gain = friction_torque_compensation_pkg::GAIN_SECOND;
                end
            end
            friction_torque_compensation_pkg::GAIN_SECOND: begin
                if (!i_second_gain_cond) begin
                    if (pos_like && i_servo_on && valid_time != '0) begin
                        nxt_st.gain   = friction_torque_compensation_pkg::GAIN_THIRD;
                        nxt_st.period = valid_time;
                        nxt_st.tick   = '0;
                    end else begin
                        nxt_st.gain = friction_torque_compensation_pkg::GAIN_FIRST;
                    end
                end
            end
            friction_torque_compensation_pkg::GAIN_THIRD: begin
                if (i_second_gain_cond) begin
                    nxt_st.gain = friction_torque_compensation_pkg::GAIN_SECOND;
                end else if (!pos_like || !i_servo_on) begin
                    nxt_st.gain = friction_torque_compensation_pkg::GAIN_FIRST;
                end else if (st_ff.tick == TICK_W'(TICK_CYCLES - 1)) begin
                    nxt_st.tick   = '0;
                    nxt_st.period = st_ff.period - VT_W'(1);
                    if (st_ff.period <= VT_W'(1)) begin
                        nxt_st.gain = friction_torque_compensation_pkg::GAIN_FIRST;
                    end
                end else begin
                    nxt_st.tick = st_ff.tick + TICK_W'(1);
                end
            end
            default: begin
                nxt_st.gain = friction_torque_compensation_pkg::GAIN_FIRST;
            end
        endcase

        // Loop gains for the selected set
        case (st_ff.gain)
            friction_torque_compensation_pkg::GAIN_THIRD: begin
                nxt_st.pos_gain = third_pos_gain;
                nxt_st.vel_gain = third_vel_gain;
            end
            friction_torque_compensation_pkg::GAIN_SECOND: begin
                nxt_st.pos_gain = {4'h0, i_second_position_gain};
                nxt_st.vel_gain = {4'h0, i_second_velocity_gain};
            end
            default: begin
                nxt_st.pos_gain = {4'h0, i_first_position_gain};
                nxt_st.vel_gain = {4'h0, i_first_velocity_gain};
            end
        endcase

        // Command direction tracking
        if (i_cmd_valid && i_cmd_delta > 0) begin
            new_dir = friction_torque_compensation_pkg::DIR_FORWARD;
        end else if (i_cmd_valid && i_cmd_delta < 0) begin
            new_dir = friction_torque_compensation_pkg::DIR_REVERSE;
        end
        if (!i_motor_energized) begin
            new_dir = friction_torque_compensation_pkg::DIR_NONE;
        end
        nxt_st.dir = new_dir;

        case (new_dir)
            friction_torque_compensation_pkg::DIR_FORWARD: dir_term = i_forward_friction_setting;
            friction_torque_compensation_pkg::DIR_REVERSE: dir_term = i_reverse_friction_setting;
            default:                                       dir_term = '0;
        endcase

        // Compensation terms per control mode
        case (i_control_mode)
            friction_torque_compensation_pkg::MODE_TORQUE: begin
                nxt_st.offset = `FTC_TERM_RESET;
                nxt_st.dyn    = `FTC_TERM_RESET;
            end
            friction_torque_compensation_pkg::MODE_VELOCITY: begin
                nxt_st.offset = i_torque_offset_setting;
                nxt_st.dyn    = i_servo_on ? dir_term : `FTC_TERM_RESET;
            end
            default: begin
                if (!i_servo_on) begin
                    nxt_st.offset = i_torque_offset_setting;
                    nxt_st.dyn    = `FTC_TERM_RESET;
                end else if (i_cmd_valid || st_ff.cmd_seen) begin
                    nxt_st.offset   = i_torque_offset_setting;
                    nxt_st.dyn      = dir_term;
                    nxt_st.cmd_seen = 1'b1;
                end
            end
        endcase
        if (!i_servo_on || !i_motor_energized) begin
            nxt_st.cmd_seen = 1'b0;
        end

        nxt_st.torque = i_torque_cmd + TQ_W'(st_ff.offset) + TQ_W'(st_ff.dyn);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign o_torque_cmd    = st_ff.torque;
    assign o_offset_term   = st_ff.offset;
    assign o_dynamic_term  = st_ff.dyn;
    assign o_cmd_dir       = st_ff.dir;
    assign o_gain_set      = st_ff.gain;
    assign o_position_gain = st_ff.pos_gain;
    assign o_velocity_gain = st_ff.vel_gain;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_THIRD_GAIN_SCALE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_ff.gain == friction_torque_compensation_pkg::GAIN_THIRD
        |=> o_position_gain == $past(third_pos_gain) && o_velocity_gain == $past(third_vel_gain))
        else $error("third gain not scaled from first gain");

    AST_TORQUE_SUM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        1'b1 |=> o_torque_cmd == $past(i_torque_cmd) + TQ_W'($past(o_offset_term))
                                 + TQ_W'($past(o_dynamic_term)))
        else $error("torque command is not input plus both terms");

    AST_TORQUE_MODE_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_control_mode == friction_torque_compensation_pkg::MODE_TORQUE
        |=> o_offset_term == '0 && o_dynamic_term == '0)
        else $error("terms not zero in torque control");

    AST_VELOCITY_SERVO_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_control_mode == friction_torque_compensation_pkg::MODE_VELOCITY && !i_servo_on
        |=> o_dynamic_term == '0 && o_offset_term == $past(i_torque_offset_setting))
        else $error("velocity servo-off terms wrong");

    AST_HOLD_BEFORE_CMD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pos_like && i_servo_on && i_motor_energized && !st_ff.cmd_seen && !i_cmd_valid
        |=> $stable(o_offset_term) && $stable(o_dynamic_term))
        else $error("terms changed before first positional command");

    AST_FORWARD_TERM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pos_like && i_servo_on && i_motor_energized && i_cmd_valid && i_cmd_delta > 0
        |=> o_dynamic_term == $past(i_forward_friction_setting)
            && o_offset_term == $past(i_torque_offset_setting))
        else $error("forward command did not load forward term");

    AST_REVERSE_TERM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pos_like && i_servo_on && i_motor_energized && i_cmd_valid && i_cmd_delta < 0
        |=> o_dynamic_term == $past(i_reverse_friction_setting))
        else $error("reverse command did not load reverse term");

    AST_DEENERGISE_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_motor_energized |=> o_cmd_dir == friction_torque_compensation_pkg::DIR_NONE)
        else $error("direction not cleared on de-energise");

    AST_ZERO_CMD_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_motor_energized && i_cmd_valid && i_cmd_delta == 0 |=> $stable(o_cmd_dir))
        else $error("zero increment changed direction");

    AST_SECOND_OVER_THIRD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_ff.gain == friction_torque_compensation_pkg::GAIN_THIRD && i_second_gain_cond
        |=> o_gain_set == friction_torque_compensation_pkg::GAIN_SECOND)
        else $error("second gain did not override third gain");

    AST_PERIOD_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_ff.gain == friction_torque_compensation_pkg::GAIN_SECOND && !i_second_gain_cond
        && pos_like && i_servo_on && valid_time != '0
        |=> st_ff.gain == friction_torque_compensation_pkg::GAIN_THIRD && st_ff.period == $past(valid_time))
        else $error("third gain period not loaded from valid time");

endmodule : friction_torque_compensation

`default_nettype wire

// [friction_torque_compensation_defines.svh]
// Constants for the friction torque compensation block
`ifndef FRICTION_TORQUE_COMPENSATION_DEFINES_SVH
`define FRICTION_TORQUE_COMPENSATION_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FTC_CLK_PERIOD_NS    10
`define FTC_VALID_UNIT_NS    100000
`define FTC_TICK_CYCLES      ((`FTC_VALID_UNIT_NS + `FTC_CLK_PERIOD_NS - 1) / `FTC_CLK_PERIOD_NS)
`define FTC_VALID_TIME_MAX   14'h2710

// ----------------------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------------------
`define FTC_SCALE_DIVISOR    100

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FTC_TERM_RESET       8'h00
`define FTC_PERIOD_RESET     14'h0000

`endif

// [friction_torque_compensation_pkg.sv]
// Types shared by the friction torque compensation block
`default_nettype none

package friction_torque_compensation_pkg;

    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_VELOCITY,
        MODE_TORQUE,
        MODE_FULL_CLOSED
    } ctrl_mode_e;

    typedef enum logic [1:0] {
        GAIN_FIRST,
        GAIN_SECOND,
        GAIN_THIRD
    } gain_set_e;

    typedef enum logic [1:0] {
        DIR_NONE,
        DIR_FORWARD,
        DIR_REVERSE
    } cmd_dir_e;

endpackage : friction_torque_compensation_pkg

`default_nettype wire

// [loop_gain_scaler.sv]
// Scales a first-set loop gain by a percentage factor
`default_nettype none
`include "friction_torque_compensation_defines.svh"

module loop_gain_scaler #(
    parameter int GAIN_W  = 16,
    parameter int SCALE_W = 11
) (
    input  wire logic [GAIN_W-1:0]  i_gain,
    input  wire logic [SCALE_W-1:0] i_scale,
    output logic      [GAIN_W+3:0]  o_gain
);

    localparam int PROD_W = GAIN_W + SCALE_W;

    logic [PROD_W-1:0] product;
    logic [PROD_W-1:0] quotient;

    always_comb begin
        product  = PROD_W'(i_gain) * PROD_W'(i_scale);
        quotient = product / PROD_W'(`FTC_SCALE_DIVISOR);
        o_gain   = quotient[GAIN_W+3:0];
    end

endmodule : loop_gain_scaler

`default_nettype wire

// [host_command_model.sv]
// Host controller model that issues positional command increments
`default_nettype none

module host_command_model (
    input  wire logic          i_clk_sys,
    output logic               o_cmd_valid,
    output logic signed [31:0] o_cmd_delta
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_delta = 32'h0000_0000;
    end

    // One command per call; calls in a row give one per cycle
    task automatic send(input int delta);
        @(posedge i_clk_sys);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_delta = delta;
    endtask : send

    // No command; increment toggles so a stale value is never trusted
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            #1;
            o_cmd_valid = 1'b0;
            o_cmd_delta = ~o_cmd_delta;
        end
    endtask : idle
endmodule : host_command_model

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the friction torque compensation block
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TICK = 4;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                                         clk_sys = 1'b0;
    logic                                         rst_n, servo_on, energized, cond, cmd_valid;
    logic                                         live = 1'b0;
    friction_torque_compensation_pkg::ctrl_mode_e mode;
    friction_torque_compensation_pkg::cmd_dir_e   dir_out, m_dir;
    friction_torque_compensation_pkg::gain_set_e  gs_out, m_gs;
    logic signed [31:0]                           cmd_delta;
    logic signed [15:0]                           torque_cmd, torque_out, m_tq;
    logic signed [7:0]                            offset_set, fwd_set, rev_set, off_out, dyn_out, m_off, m_dyn;
    logic [15:0]                                  pos1, vel1, pos2, vel2;
    logic [10:0]                                  scale;
    logic [13:0]                                  valid_time;
    logic [19:0]                                  pg_out, vg_out, m_pg, m_vg;
    logic                                         m_seen;
    int                                           m_left, failures = 0, num_checks = 0, cycles = 0;
    integer                                       seed;

    always #5 clk_sys = ~clk_sys;

    host_command_model host (.i_clk_sys(clk_sys), .o_cmd_valid(cmd_valid), .o_cmd_delta(cmd_delta));

    friction_torque_compensation #(.TICK_CYCLES(TICK)) dut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_control_mode(mode), .i_servo_on(servo_on),
        .i_motor_energized(energized), .i_cmd_valid(cmd_valid), .i_cmd_delta(cmd_delta),
        .i_torque_cmd(torque_cmd), .i_torque_offset_setting(offset_set),
        .i_forward_friction_setting(fwd_set), .i_reverse_friction_setting(rev_set),
        .i_first_position_gain(pos1), .i_first_velocity_gain(vel1), .i_second_position_gain(pos2),
        .i_second_velocity_gain(vel2), .i_third_gain_scale(scale), .i_third_gain_valid_time(valid_time),
        .i_second_gain_cond(cond), .o_torque_cmd(torque_out), .o_offset_term(off_out),
        .o_dynamic_term(dyn_out), .o_cmd_dir(dir_out), .o_gain_set(gs_out),
        .o_position_gain(pg_out), .o_velocity_gain(vg_out));

    // ------------------------------------------------------------------
    // Reference model and comparison
    // ------------------------------------------------------------------
    function automatic logic [19:0] pick(input logic [15:0] first, input logic [15:0] second);
        if (m_gs == friction_torque_compensation_pkg::GAIN_SECOND) return 20'(second);
        if (m_gs == friction_torque_compensation_pkg::GAIN_THIRD) return 20'(int'(first) * int'(scale) / 100);
        return 20'(first);
    endfunction : pick

    always @(posedge clk_sys) begin : model
        friction_torque_compensation_pkg::cmd_dir_e nd;
        logic signed [7:0]                          sel;
        logic                                       ps;
        live = 1'b1;
        if (!rst_n) begin
            {m_tq, m_off, m_dyn, m_pg, m_vg, m_seen} = '0;
            m_dir = friction_torque_compensation_pkg::DIR_NONE;
            m_gs = friction_torque_compensation_pkg::GAIN_FIRST;
        end else begin
            m_tq = torque_cmd + m_off + m_dyn;
            m_pg = pick(pos1, pos2);
            m_vg = pick(vel1, vel2);
            ps = mode == friction_torque_compensation_pkg::MODE_POSITION ||
                 mode == friction_torque_compensation_pkg::MODE_FULL_CLOSED;
            nd = m_dir;
            if (!energized) nd = friction_torque_compensation_pkg::DIR_NONE;
            else if (cmd_valid && cmd_delta > 0) nd = friction_torque_compensation_pkg::DIR_FORWARD;
            else if (cmd_valid && cmd_delta < 0) nd = friction_torque_compensation_pkg::DIR_REVERSE;
            sel = (nd == friction_torque_compensation_pkg::DIR_FORWARD) ? fwd_set :
                  (nd == friction_torque_compensation_pkg::DIR_REVERSE) ? rev_set : 8'sh00;
            m_dir = nd;
            if (mode == friction_torque_compensation_pkg::MODE_TORQUE) begin
                m_off = 8'sh00;
                m_dyn = 8'sh00;
            end else if (!servo_on) begin
                m_off = offset_set;
                m_dyn = 8'sh00;
                m_seen = 1'b0;
            end else if (!ps || m_seen || cmd_valid) begin
                m_off = offset_set;
                m_dyn = sel;
                m_seen = m_seen | ps;
            end
            if (!servo_on || !energized) m_seen = 1'b0;
            if (m_gs == friction_torque_compensation_pkg::GAIN_FIRST) begin
                if (cond) m_gs = friction_torque_compensation_pkg::GAIN_SECOND;
            end else if (m_gs == friction_torque_compensation_pkg::GAIN_SECOND) begin
                if (!cond) begin
                    m_left = (valid_time > 14'h2710 ? 10000 : int'(valid_time)) * TICK;
                    m_gs = (ps && servo_on && m_left != 0) ? friction_torque_compensation_pkg::GAIN_THIRD :
                           friction_torque_compensation_pkg::GAIN_FIRST;
                end
            end else begin
                m_left = m_left - 1;
                if (cond) m_gs = friction_torque_compensation_pkg::GAIN_SECOND;
                else if (!ps || !servo_on || m_left == 0) m_gs = friction_torque_compensation_pkg::GAIN_FIRST;
            end
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    always @(negedge clk_sys) begin
        if (live) begin
            check("torque", 32'(torque_out), 32'(m_tq));
            check("offset", 32'(off_out), 32'(m_off));
            check("dynamic", 32'(dyn_out), 32'(m_dyn));
            check("direction", 32'(dir_out), 32'(m_dir));
            check("gain set", 32'(gs_out), 32'(m_gs));
            check("pos gain", 32'(pg_out), 32'(m_pg));
            check("vel gain", 32'(vg_out), 32'(m_vg));
        end
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic new_settings();
        offset_set = 8'($random(seed) % 101);
        fwd_set = 8'($random(seed) % 101);
        rev_set = 8'($random(seed) % 101);
        {pos1, vel1, pos2, vel2} = {$random(seed), $random(seed)};
        scale = 11'(50 + (($random(seed) & 32'h0000_03FF) % 951));
        valid_time = 14'(1 + ($random(seed) & 32'h0000_0003));
    endtask : new_settings

    // Forward, reverse back to back, then a zero increment
    task automatic run_cmds();
        host.send(1 + ($random(seed) & 32'h0000_00FF));
        host.send(-1 - ($random(seed) & 32'h0000_00FF));
        host.send(0);
        host.idle(3);
    endtask : run_cmds

    always @(posedge clk_sys) begin
        #1;
        torque_cmd = 16'($random(seed));
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        seed = 32'h2BEC76EA;
        {rst_n, servo_on, energized, cond, torque_cmd} = '0;
        mode = friction_torque_compensation_pkg::MODE_POSITION;
        new_settings();
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        host.idle(3);
        energized = 1'b1;
        servo_on = 1'b1;
        host.idle(2);
        new_settings();
        host.idle(4);
        run_cmds();
        servo_on = 1'b0;
        host.idle(2);
        mode = friction_torque_compensation_pkg::MODE_FULL_CLOSED;
        servo_on = 1'b1;
        host.idle(2);
        new_settings();
        host.idle(2);
        run_cmds();
        servo_on = 1'b0;
        mode = friction_torque_compensation_pkg::MODE_VELOCITY;
        new_settings();
        run_cmds();
        servo_on = 1'b1;
        run_cmds();
        mode = friction_torque_compensation_pkg::MODE_TORQUE;
        run_cmds();
        energized = 1'b0;
        servo_on = 1'b0;
        host.idle(3);
        energized = 1'b1;
        mode = friction_torque_compensation_pkg::MODE_POSITION;
        servo_on = 1'b1;
        // Full third-gain period, then one cut short by the second-gain condition
        cond = 1'b1;
        host.idle(3);
        cond = 1'b0;
        host.idle(int'(valid_time) * TICK + 4);
        cond = 1'b1;
        host.idle(3);
        cond = 1'b0;
        host.idle(5);
        cond = 1'b1;
        host.idle(3);
        cond = 1'b0;
        host.idle(3);
        servo_on = 1'b0;
        host.idle(3);
        servo_on = 1'b1;
        valid_time = 14'h0000;
        cond = 1'b1;
        host.idle(2);
        cond = 1'b0;
        host.idle(3);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
